/* File: switch_irq_defines.vh */
// constants for the switch input configuration and interrupt pin block
`ifndef SWITCH_IRQ_DEFINES_VH
`define SWITCH_IRQ_DEFINES_VH

// ****************************************
// geometry
// ****************************************
`define NUM_INPUTS      24
`define NUM_INDIV       12
`define FIRST_TWO_LVL   5'h0C
`define FIRST_THREE_LVL 5'h12
`define LAST_INPUT      5'h17
`define GROUP_SIZE      4
`define ADC_W           10
`define SLOT_SEL_W      3
`define WET_W           3
`define CMP_W           2

// ****************************************
// reset values
// ****************************************
`define RST_ENABLE      24'h000000
`define RST_MODE        24'h000000
`define RST_SCHEME      1'b0

// ****************************************
// encodings
// ****************************************
`define SCHEME_STATIC   1'b0
`define SCHEME_DYNAMIC  1'b1
`define MODE_COMP       1'b0
`define MODE_ADC        1'b1
`define CMP_2V0         2'h0
`define CMP_2V7         2'h1
`define CMP_3V0         2'h2
`define CMP_4V0         2'h3
`define WET_0MA         3'h0
`define WET_1MA         3'h1
`define WET_2MA         3'h2
`define WET_5MA         3'h3
`define WET_10MA        3'h4
`define WET_15MA        3'h5

// ****************************************
// timing
// ****************************************
`define CLK_NS          40
`define T_ACTIVE_NS     2000
`define T_INACTIVE_NS   2000
`define ACTIVE_CYC   ((`T_ACTIVE_NS + `CLK_NS - 1) / `CLK_NS)
`define INACTIVE_CYC ((`T_INACTIVE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

/* File: pin_sync_edge.v */
// two-stage synchroniser with edge detection for a foreign-domain pin
`timescale 1ns/10ps
module pin_sync_edge #(
  parameter RST_VAL = 1'b1
) (
  // clock and reset
  input  wire clk,
  input  wire srst,
  // pin side
  input  wire pin,
  // synchronised side
  output reg  level,
  output wire rise,
  output wire fall
);
  reg meta;
  reg prev;

  // meta feeds only the second stage; edges compare stage two and three
  always @(posedge clk) begin
    if (srst) begin
      meta  <= RST_VAL;
      level <= RST_VAL;
      prev  <= RST_VAL;
    end else begin
      meta  <= pin;
      level <= meta;
      prev  <= level;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;
endmodule // pin_sync_edge

/* File: switch_input_cfg_irq.v */
// input configuration, threshold compare and interrupt pin logic
// Contract
// - per-input mode bit picks comparator or adc; comparator after reset
// - disabled input: wetting current off, no monitoring
// - all enables clear after reset
// - comparator level shared by each group of four inputs
// - comparator level is one of four: 2 V, 2.7 V, 3 V, 4 V
// - adc thresholds are 10-bit codes
// - inputs 0..11 each map to one of eight individual slots
// - shared adc level for inputs 0..11 compared in addition to slots
// - inputs 12..17 compare against shared low and high levels
// - inputs 18..22 compare against three shared levels
// - input 23 compares against those three plus two own levels
// - six wetting settings, 0 mA after reset
// - interrupt pin active low open drain, pulled on events
// - static scheme: low until cs rise ends a status read
// - status snapshot on first sclk rise after cs fall; read clears
// - dynamic scheme: pulse low, high, repeat until status read
// - dynamic read while low: release and clear at cs rise
// - dynamic read while high: clear at cs rise, no new pulse
// - scheme resets to static
// - scheme change accepted only while run trigger is low
`timescale 1ns/10ps
`include "switch_irq_defines.vh"
module switch_input_cfg_irq #(
  parameter STAT_W       = 16,
  parameter ACTIVE_CYC   = `ACTIVE_CYC,
  parameter INACTIVE_CYC = `INACTIVE_CYC
) (
  // clock and reset
  input  wire                 clk,
  input  wire                 srst,
  // run control
  input  wire                 run_trigger,
  input  wire                 scheme_req,
  output reg                  scheme,
  // per-input configuration
  input  wire [23:0]          in_enable,
  input  wire [23:0]          in_mode,
  input  wire [11:0]          comparator_level_select,
  input  wire [35:0]          wetting_cfg_a,
  input  wire [35:0]          wetting_cfg_b,
  // adc thresholds
  input  wire [79:0]          level_slots,
  input  wire [35:0]          level_mapping_reg,
  input  wire [9:0]           shared_adc_level,
  input  wire [9:0]           two_level_low,
  input  wire [9:0]           two_level_high,
  input  wire [9:0]           three_level_low,
  input  wire [9:0]           three_level_mid,
  input  wire [9:0]           three_level_high,
  input  wire [9:0]           last_input_level_four,
  input  wire [9:0]           last_input_level_five,
  // per-input drive to the analog front end
  output reg  [23:0]          wetting_on,
  output reg  [71:0]          wetting_sel,
  output reg  [23:0]          comp_active,
  output reg  [47:0]          comp_level,
  output reg  [23:0]          adc_active,
  // adc sample in, compare result out
  input  wire                 adc_valid,
  input  wire [4:0]           adc_channel,
  input  wire [9:0]           adc_code,
  output reg                  adc_res_valid,
  output reg  [4:0]           adc_res_channel,
  output reg  [4:0]           adc_res_above,
  // interrupt status
  input  wire [STAT_W-1:0]    event_set,
  output reg  [STAT_W-1:0]    int_status,
  output reg  [STAT_W-1:0]    status_snapshot,
  // serial port pins and command decode
  input  wire                 cs_n,
  input  wire                 sclk,
  input  wire                 status_read,
  // interrupt pin, open drain
  output wire                 int_n_o,
  output reg                  int_n_oe
);

  // ****************************************
  // functions
  // ****************************************
  function at_or_above;
    input [9:0] code;
    input [9:0] lvl;
    begin
      at_or_above = (code >= lvl);
    end
  endfunction

  // unknown wetting codes fall back to 0 mA rather than an odd current
  function [2:0] wet_legal;
    input [2:0] c;
    begin
      if (c <= `WET_15MA)
        wet_legal = c;
      else
        wet_legal = `WET_0MA;
    end
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  wire cs_level;
  wire cs_rise;
  wire cs_fall;
  wire sclk_rise;

  pin_sync_edge #(.RST_VAL(1'b1)) u_cs (
    .clk   (clk),
    .srst  (srst),
    .pin   (cs_n),
    .level (cs_level),
    .rise  (cs_rise),
    .fall  (cs_fall)
  );

  pin_sync_edge #(.RST_VAL(1'b0)) u_sclk (
    .clk   (clk),
    .srst  (srst),
    .pin   (sclk),
    .level (),
    .rise  (sclk_rise),
    .fall  ()
  );

  // ****************************************
  // scheme select
  // ****************************************
  always @(posedge clk) begin
    if (srst)
      scheme <= `RST_SCHEME;
    else if (!run_trigger)
      scheme <= scheme_req;
  end

  // ****************************************
  // per-input drive
  // ****************************************
  wire [71:0] wet_raw;
  assign wet_raw = {wetting_cfg_b, wetting_cfg_a};

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_INPUTS; gi = gi + 1) begin : g_in
      always @(posedge clk) begin
        if (srst) begin
          wetting_on[gi]            <= 1'b0;
          wetting_sel[gi*3 +: 3]    <= `WET_0MA;
          comp_active[gi]           <= 1'b0;
          comp_level[gi*2 +: 2]     <= `CMP_2V0;
          adc_active[gi]            <= 1'b0;
        end else begin
          wetting_on[gi] <= in_enable[gi];
          if (in_enable[gi])
            wetting_sel[gi*3 +: 3] <= wet_legal(wet_raw[gi*3 +: 3]);
          else
            wetting_sel[gi*3 +: 3] <= `WET_0MA;
          comp_active[gi] <= in_enable[gi] &
                             (in_mode[gi] == `MODE_COMP);
          adc_active[gi]  <= in_enable[gi] &
                             (in_mode[gi] == `MODE_ADC);
          // two select bits can only name the four levels
          comp_level[gi*2 +: 2] <=
            comparator_level_select[(gi/`GROUP_SIZE)*2 +: 2];
        end
      end
    end
  endgenerate

  // ****************************************
  // adc threshold compare
  // ****************************************
  reg [4:0] next_above;
  reg [2:0] slot_sel;
  reg [9:0] slot_lvl;
  wire      ch_live;

  assign ch_live = (adc_channel <= `LAST_INPUT) &&
                   adc_active[adc_channel];

  always @* begin
    next_above = 5'h00;
    slot_sel   = 3'h0;
    slot_lvl   = 10'h000;
    if (adc_channel < `FIRST_TWO_LVL) begin
      // only the first twelve inputs own a mapping entry
      slot_sel = level_mapping_reg[adc_channel*3 +: 3];
      slot_lvl = level_slots[slot_sel*10 +: 10];
      next_above[0] = at_or_above(adc_code, slot_lvl);
      next_above[1] = at_or_above(adc_code, shared_adc_level);
    end else if (adc_channel < `FIRST_THREE_LVL) begin
      next_above[0] = at_or_above(adc_code, two_level_low);
      next_above[1] = at_or_above(adc_code, two_level_high);
    end else begin
      next_above[0] = at_or_above(adc_code, three_level_low);
      next_above[1] = at_or_above(adc_code, three_level_mid);
      next_above[2] = at_or_above(adc_code, three_level_high);
      if (adc_channel == `LAST_INPUT) begin
        next_above[3] = at_or_above(adc_code,
                                    last_input_level_four);
        next_above[4] = at_or_above(adc_code,
                                    last_input_level_five);
      end
    end
  end

  // levels are taken as given; out-of-order settings yield odd patterns
  always @(posedge clk) begin
    if (srst) begin
      adc_res_valid   <= 1'b0;
      adc_res_channel <= 5'h00;
      adc_res_above   <= 5'h00;
    end else begin
      adc_res_valid <= adc_valid & ch_live;
      if (adc_valid && ch_live) begin
        adc_res_channel <= adc_channel;
        adc_res_above   <= next_above;
      end
    end
  end

  // ****************************************
  // transaction tracking and status
  // ****************************************
  reg  first_clk_seen;
  reg  read_seen;
  wire clear_now;

  assign clear_now = cs_rise & (read_seen | status_read);

  always @(posedge clk) begin
    if (srst) begin
      first_clk_seen <= 1'b1;
      read_seen      <= 1'b0;
    end else begin
      if (cs_fall)
        first_clk_seen <= 1'b0;
      else if (sclk_rise && !cs_level)
        first_clk_seen <= 1'b1;
      if (cs_rise)
        read_seen <= 1'b0;
      else if (status_read && !cs_level)
        read_seen <= 1'b1;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      int_status      <= {STAT_W{1'b0}};
      status_snapshot <= {STAT_W{1'b0}};
    end else begin
      // new events win over a clear in the same cycle
      if (clear_now)
        int_status <= event_set;
      else
        int_status <= int_status | event_set;
      if (!first_clk_seen && sclk_rise && !cs_level)
        status_snapshot <= int_status | event_set;
    end
  end

  // ****************************************
  // interrupt pin sequencer
  // ****************************************
  localparam ST_IDLE     = 2'h0;
  localparam ST_ACTIVE   = 2'h1;
  localparam ST_INACTIVE = 2'h2;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [15:0] cnt;
  reg  [15:0] next_cnt;
  reg         next_oe;
  wire        pending;

  assign pending = |int_status;

  always @* begin
    next_state = state;
    next_cnt   = cnt;
    next_oe    = 1'b0;
    case (state)
      ST_IDLE: begin
        if (pending && !clear_now) begin
          next_state = ST_ACTIVE;
          next_cnt   = 16'h0000;
          next_oe    = 1'b1;
        end
      end
      ST_ACTIVE: begin
        next_oe = 1'b1;
        if (clear_now) begin
          next_state = ST_IDLE;
          next_oe    = 1'b0;
        end else if (scheme == `SCHEME_DYNAMIC &&
                     cnt == ACTIVE_CYC - 1) begin
          next_state = ST_INACTIVE;
          next_cnt   = 16'h0000;
          next_oe    = 1'b0;
        end else if (scheme == `SCHEME_DYNAMIC) begin
          next_cnt = cnt + 16'h0001;
        end
        // static scheme simply holds the pin low
      end
      ST_INACTIVE: begin
        if (clear_now) begin
          next_state = ST_IDLE;
        end else if (cnt == INACTIVE_CYC - 1) begin
          next_state = ST_ACTIVE;
          next_cnt   = 16'h0000;
          next_oe    = 1'b1;
        end else begin
          next_cnt = cnt + 16'h0001;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_cnt   = 16'h0000;
      end
    endcase
  end

  // the scheme moves whenever run_trigger is low, even in the middle of a pulse
  always @(posedge clk) begin
    if (srst) begin
      state    <= ST_IDLE;
      cnt      <= 16'h0000;
      int_n_oe <= 1'b0;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      int_n_oe <= next_oe;
    end
  end

  // open drain: the pin is only ever driven low
  assign int_n_o = 1'b0;
endmodule // switch_input_cfg_irq

/* File: switch_input_cfg_irq_checker.sv */
// assertion checker for the switch configuration and interrupt pin block
`timescale 1ns/10ps
module switch_input_cfg_irq_checker #(
  parameter STAT_W     = 16,
  parameter ACTIVE_CYC = 50
) (
  // clock and reset
  input wire              clk,
  input wire              srst,
  // configuration
  input wire              run_trigger,
  input wire              scheme_req,
  input wire              scheme,
  input wire [23:0]       in_enable,
  input wire [23:0]       in_mode,
  input wire [23:0]       wetting_on,
  input wire [71:0]       wetting_sel,
  input wire [23:0]       comp_active,
  input wire [23:0]       adc_active,
  // adc compare
  input wire              adc_valid,
  input wire [4:0]        adc_channel,
  input wire [9:0]        adc_code,
  input wire [9:0]        two_level_low,
  input wire [9:0]        two_level_high,
  input wire              adc_res_valid,
  input wire [4:0]        adc_res_above,
  // status and pin
  input wire [STAT_W-1:0] int_status,
  input wire [STAT_W-1:0] event_set,
  input wire [STAT_W-1:0] status_snapshot,
  input wire              cs_n,
  input wire              int_n_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  reg [7:0] hi_cnt;
  // cycles the pin has been pulled so far, for the pulse length bound
  always @(posedge clk) begin
    if (srst || !int_n_oe)
      hi_cnt <= 8'h00;
    else
      hi_cnt <= hi_cnt + 8'h01;
  end
  property p_reset_vals;
    $fell(srst) |-> !scheme && wetting_on == 24'h000000 && !int_n_oe;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("outputs not at reset values");
  property p_disabled;
    in_enable == 24'h000000 |=> wetting_on == 24'h000000 &&
      wetting_sel == 72'h0 && (comp_active | adc_active) == 24'h000000;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("disabled inputs still driven");
  property p_mode_split;
    1'b1 |=> comp_active == $past(in_enable & ~in_mode) &&
      adc_active == $past(in_enable & in_mode);
  endproperty
  a_mode_split: assert property (p_mode_split)
    else $error("mode split wrong");
  property p_scheme_gate;
    1'b1 |=> scheme ==
      ($past(run_trigger) ? $past(scheme) : $past(scheme_req));
  endproperty
  a_scheme_gate: assert property (p_scheme_gate)
    else $error("scheme changed while running");
  property p_adc_two;
    adc_valid && adc_channel == 5'h0C && adc_active[12] |=> adc_res_valid &&
      adc_res_above[1:0] == {$past(adc_code) >= $past(two_level_high),
                             $past(adc_code) >= $past(two_level_low)};
  endproperty
  a_adc_two: assert property (p_adc_two)
    else $error("two level compare wrong");
  property p_adc_refuse;
    adc_valid && !adc_active[adc_channel] |=> !adc_res_valid;
  endproperty
  a_adc_refuse: assert property (p_adc_refuse)
    else $error("inactive input produced a result");
  property p_snapshot;
    status_snapshot != $past(status_snapshot) |->
      status_snapshot == $past(int_status | event_set);
  endproperty
  a_snapshot: assert property (p_snapshot)
    else $error("snapshot not a status image");
  property p_static_release;
    !scheme && $fell(int_n_oe) |-> $past(cs_n) && $past(cs_n, 3);
  endproperty
  a_static_release: assert property (p_static_release)
    else $error("static pin released inside a frame");
  property p_dyn_active;
    scheme && int_n_oe |-> hi_cnt < ACTIVE_CYC;
  endproperty
  a_dyn_active: assert property (p_dyn_active)
    else $error("dynamic pulse too long");
  c_static: cover property (!scheme && $fell(int_n_oe));
  c_dynamic: cover property (scheme && $fell(int_n_oe));
  c_adc: cover property (adc_res_valid);
endmodule // switch_input_cfg_irq_checker

bind switch_input_cfg_irq switch_input_cfg_irq_checker #(
  .STAT_W(STAT_W),
  .ACTIVE_CYC(ACTIVE_CYC)
) u_chk (
  .clk(clk), .srst(srst), .run_trigger(run_trigger),
  .scheme_req(scheme_req), .scheme(scheme), .in_enable(in_enable),
  .in_mode(in_mode), .wetting_on(wetting_on), .wetting_sel(wetting_sel),
  .comp_active(comp_active), .adc_active(adc_active),
  .adc_valid(adc_valid), .adc_channel(adc_channel), .adc_code(adc_code),
  .two_level_low(two_level_low), .two_level_high(two_level_high),
  .adc_res_valid(adc_res_valid), .adc_res_above(adc_res_above),
  .int_status(int_status), .event_set(event_set),
  .status_snapshot(status_snapshot), .cs_n(cs_n), .int_n_oe(int_n_oe)
);

/* File: host_mcu_model.sv */
// host controller model driving the serial frame pins
`timescale 1ns/10ps
module host_mcu_model (
  // clock
  input  wire clk,
  // serial frame pins and command decode
  output reg  cs_n,
  output reg  sclk,
  output reg  status_read
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    status_read = 1'b0;
  end
  // two serial clocks at 320 ns; sclk stands still outside frames
  task frame(input rd);
    begin
      @(negedge clk) cs_n <= 1'b0;
      repeat (4) begin
        repeat (4) @(negedge clk);
        sclk <= ~sclk;
      end
      if (rd) begin
        @(negedge clk) status_read <= 1'b1;
        @(negedge clk) status_read <= 1'b0;
      end
      repeat (3) @(negedge clk);
      cs_n <= 1'b1;
      repeat (8) @(negedge clk);
    end
  endtask
endmodule // host_mcu_model

/* File: switch_input_cfg_irq_tb_top.sv */
// self-checking testbench for the switch configuration and interrupt pin
`timescale 1ns/10ps
module switch_input_cfg_irq_tb_top;
  localparam ACT = 4;
  localparam INACT = 3;
  reg         clk, srst, run_trigger, scheme_req, adc_valid;
  reg  [23:0] in_enable, in_mode;
  reg  [11:0] comparator_level_select;
  reg  [35:0] wetting_cfg_a, wetting_cfg_b, level_mapping_reg;
  reg  [79:0] level_slots;
  reg  [9:0]  shared_adc_level, two_level_low, two_level_high, adc_code;
  reg  [9:0]  three_level_low, three_level_mid, three_level_high;
  reg  [9:0]  last_input_level_four, last_input_level_five;
  reg  [4:0]  adc_channel;
  reg  [15:0] event_set;
  wire        scheme, adc_res_valid, cs_n, sclk, status_read;
  wire        int_n_o, int_n_oe;
  wire [23:0] wetting_on, comp_active, adc_active;
  wire [71:0] wetting_sel;
  wire [47:0] comp_level;
  wire [4:0]  adc_res_channel, adc_res_above;
  wire [15:0] int_status, status_snapshot;
  integer     n_errors, n_compared, cycles, i, k;
  switch_input_cfg_irq #(.ACTIVE_CYC(ACT), .INACTIVE_CYC(INACT)) DUT (
    .clk(clk), .srst(srst), .run_trigger(run_trigger),
    .scheme_req(scheme_req), .scheme(scheme), .in_enable(in_enable),
    .in_mode(in_mode), .comparator_level_select(comparator_level_select),
    .wetting_cfg_a(wetting_cfg_a), .wetting_cfg_b(wetting_cfg_b),
    .level_slots(level_slots), .level_mapping_reg(level_mapping_reg),
    .shared_adc_level(shared_adc_level), .two_level_low(two_level_low),
    .two_level_high(two_level_high), .three_level_low(three_level_low),
    .three_level_mid(three_level_mid),
    .three_level_high(three_level_high),
    .last_input_level_four(last_input_level_four),
    .last_input_level_five(last_input_level_five),
    .wetting_on(wetting_on), .wetting_sel(wetting_sel),
    .comp_active(comp_active), .comp_level(comp_level),
    .adc_active(adc_active), .adc_valid(adc_valid),
    .adc_channel(adc_channel), .adc_code(adc_code),
    .adc_res_valid(adc_res_valid), .adc_res_channel(adc_res_channel),
    .adc_res_above(adc_res_above), .event_set(event_set),
    .int_status(int_status), .status_snapshot(status_snapshot),
    .cs_n(cs_n), .sclk(sclk), .status_read(status_read),
    .int_n_o(int_n_o), .int_n_oe(int_n_oe)
  );
  host_mcu_model host (.clk(clk), .cs_n(cs_n), .sclk(sclk),
                       .status_read(status_read));
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      n_errors = n_errors + 1;
      tally_and_finish;
    end
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task chk(input [79:0] got, input [79:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task adc(input [4:0] ch, input [9:0] code, input v, input [4:0] exp);
    begin
      adc_valid = 1'b1;
      adc_channel = ch;
      adc_code = code;
      @(negedge clk);
      // valid drops here so back-to-back calls never reassign it at once
      adc_valid = 1'b0;
      chk(adc_res_valid, v);
      if (v) begin
        chk(adc_res_channel, ch);
        chk(adc_res_above, exp);
      end
      @(negedge clk);
      chk(adc_res_valid, 1'b0);
    end
  endtask
  task pulse_event(input [15:0] ev);
    begin
      event_set = ev;
      @(negedge clk) event_set = 16'h0000;
      repeat (2) @(negedge clk);
    end
  endtask
  task tally_and_finish;
    begin
      if (n_errors == 0 && n_compared > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_config;
    reg [71:0] wc, ws;
    begin
      run_trigger = 1'b0;
      in_mode = 24'hC4F00F;
      comparator_level_select = 12'h0E4;
      for (i = 0; i < 24; i = i + 1) begin
        wc[3*i+:3] = i[2:0];
        ws[3*i+:3] = (i < 16 && i[2:0] < 3'h6) ? i[2:0] : 3'h0;
      end
      {wetting_cfg_b, wetting_cfg_a} = wc;
      in_enable = 24'hFFFFFF;
      @(negedge clk);
      // groups 1..3 select levels 1..3, groups 0, 4 and 5 level 0
      chk(comp_level, 48'h0000FFAA5500);
      chk(comp_active, 24'h3B0FF0);
      chk(adc_active, 24'hC4F00F);
      in_enable = 24'h00FFFF;
      @(negedge clk);
      chk(wetting_on, 24'h00FFFF);
      chk(wetting_sel, ws);
      in_enable = 24'hFFFFFF;
      @(negedge clk);
    end
  endtask
  task t_adc;
    begin
      for (i = 0; i < 8; i = i + 1)
        level_slots[10*i+:10] = 10'h040 * i;
      level_mapping_reg = 36'h5;
      shared_adc_level = 10'h100;
      {two_level_low, two_level_high} = {10'h100, 10'h200};
      three_level_low = 10'h100;
      three_level_mid = 10'h180;
      three_level_high = 10'h200;
      last_input_level_four = 10'h280;
      last_input_level_five = 10'h3FF;
      adc(5'h00, 10'h140, 1'b1, 5'h03);
      adc(5'h00, 10'h13F, 1'b1, 5'h02);
      adc(5'h0C, 10'h1FF, 1'b1, 5'h01);
      adc(5'h0C, 10'h200, 1'b1, 5'h03);
      adc(5'h12, 10'h180, 1'b1, 5'h03);
      adc(5'h17, 10'h280, 1'b1, 5'h0F);
      adc(5'h04, 10'h3FF, 1'b0, 5'h00);
      adc(5'h1F, 10'h3FF, 1'b0, 5'h00);
      two_level_low = 10'h200;
      adc(5'h0C, 10'h1FF, 1'b1, 5'h00);
      adc(5'h0C, 10'h200, 1'b1, 5'h03);
    end
  endtask
  task t_static;
    begin
      pulse_event(16'h0005);
      chk(int_n_oe, 1'b1);
      host.frame(1'b0);
      chk(status_snapshot, 16'h0005);
      chk(int_n_oe, 1'b1);
      host.frame(1'b1);
      chk(int_n_oe, 1'b0);
      chk(int_status, 16'h0000);
    end
  endtask
  task t_dynamic;
    begin
      run_trigger = 1'b1;
      scheme_req = 1'b1;
      repeat (2) @(negedge clk);
      chk(scheme, 1'b0);
      run_trigger = 1'b0;
      repeat (2) @(negedge clk);
      chk(scheme, 1'b1);
      // pass 0 clears inside a low pulse, pass 1 two clocks later in a gap
      for (i = 0; i < 2; i = i + 1) begin
        event_set = 16'h0100;
        @(negedge clk) event_set = 16'h0000;
        for (k = 0; k < 10 && int_n_oe !== 1'b1; k = k + 1)
          @(negedge clk);
        for (k = 0; k < 2 * (ACT + INACT) + 2 * i; k = k + 1) begin
          chk(int_n_oe, (k % (ACT + INACT)) < ACT);
          @(negedge clk);
        end
        host.frame(1'b1);
        for (k = 0; k < 2 * (ACT + INACT); k = k + 1) begin
          chk(int_n_oe, 1'b0);
          @(negedge clk);
        end
        chk(int_status, 16'h0000);
      end
    end
  endtask
  initial begin
    {clk, run_trigger, scheme_req, adc_valid, adc_channel} = 0;
    {in_enable, in_mode, comparator_level_select, adc_code} = 0;
    {wetting_cfg_a, wetting_cfg_b, level_mapping_reg, level_slots} = 0;
    {shared_adc_level, two_level_low, two_level_high} = 0;
    {three_level_low, three_level_mid, three_level_high} = 0;
    {last_input_level_four, last_input_level_five, event_set} = 0;
    {n_errors, n_compared, cycles} = 0;
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    chk(scheme, 1'b0);
    chk(wetting_sel, 72'h0);
    chk(comp_active | adc_active, 24'h000000);
    chk(int_n_oe, 1'b0);
    chk(int_n_o, 1'b0);
    chk(wetting_on, 24'h000000);
    repeat (3) @(negedge clk);
    t_config;
    t_adc;
    t_static;
    t_dynamic;
    tally_and_finish;
  end
endmodule // switch_input_cfg_irq_tb_top
